// ==== sss_pkg.sv ====
package sss_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    // one timer unit is 0.1 s
    localparam int TICK_NS = 100_000_000;
    localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
    // pause between steps in the stop-intervention modes, in timer units
    localparam int GAP_TICKS = 1;

    // ------------------------------------------------------------
    // limits and codes
    // ------------------------------------------------------------
    // 400.00 Hz in 0.01 Hz units
    localparam logic [15:0] FREQ_MAX = 16'h9C40;
    // 6500.0 s in 0.1 s units
    localparam logic [15:0] TIMER_MAX = 16'hFDE8;
    localparam logic [2:0] RUN_MODE_INTERNAL = 3'h4;
    localparam logic [2:0] LAST_STEP = 3'h7;
    localparam logic [3:0] TIMER_IDX_BASE = 4'h8;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_RAMP = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_TIMER_NOW = 8'h10;
    // 0x40..0x5C frequencies, 0x60..0x7C timers
    localparam logic [1:0] TABLE_PAGE = 2'h1;
    localparam int CTRL_RUN_LSB = 0;
    localparam int CTRL_SEQ_LSB = 4;

    typedef enum logic [1:0] {
        SEQ_ONCE = 2'b00,
        SEQ_CYCLE = 2'b01,
        SEQ_ONCE_STOP = 2'b10,
        SEQ_CYCLE_STOP = 2'b11
    } sss_seq_mode_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_RDF = 3'b001,
        S_RDT = 3'b010,
        S_CHK = 3'b011,
        S_RUN = 3'b100,
        S_GAP = 3'b101
    } sss_state_t;

endpackage : sss_pkg

// ==== sss_sequencer.sv ====
`timescale 1ns/100ps
module sss_sequencer #(
    parameter int TICK_CYCLES = sss_pkg::TICK_CYCLES,
    parameter int GAP_TICKS = sss_pkg::GAP_TICKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic run_cmd,
    input wire logic stop_cmd,
    input wire logic ext_fault,
    input wire logic estop,
    input wire logic ext_fwd_rev,
    output logic [15:0] out_freq,
    output logic out_reverse,
    output logic [1:0] out_ramp_sel,
    output logic out_run,
    output logic seq_active
);
    import sss_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] ramp_of(input logic [15:0] w, input logic [2:0] s);
        ramp_of = w[{s, 1'b0} +: 2];
    endfunction : ramp_of

    function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lim);
        if (v[31:16] != 16'h0 || v[15:0] > lim) begin
            clamp16 = lim;
        end else begin
            clamp16 = v[15:0];
        end
    endfunction : clamp16

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    sss_state_t st_r, st_nxt;
    logic [2:0] run_mode_r;
    logic [1:0] seq_mode_r;
    logic [7:0] dir_r;
    logic [15:0] ramp_r;
    logic [2:0] step_r, step_nxt;
    logic [15:0] timer_r, timer_nxt;
    logic [15:0] gap_r, gap_nxt;
    logic [15:0] freq_r, freq_nxt;
    logic used_r, used_nxt;
    logic norm_run_r, norm_run_nxt;
    logic [23:0] div_r;
    logic [4:0] sync1_r, sync2_r;
    logic run_d_r;
    logic [15:0] out_freq_nxt;
    logic [15:0] rdata_a, rdata_b;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            run_d_r <= 1'b0;
        end else begin
            sync1_r <= {run_cmd, stop_cmd, ext_fault, estop, ext_fwd_rev};
            sync2_r <= sync1_r;
            run_d_r <= sync2_r[4];
        end
    end

    wire run_s = sync2_r[4];
    wire stop_any = sync2_r[3] | sync2_r[2] | sync2_r[1];
    wire fwd_rev_s = sync2_r[0];
    wire run_pulse = run_s & ~run_d_r;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc = psel & penable;
    wire aligned = paddr[1:0] == 2'h0;
    wire sel_ctrl = paddr == OFS_CTRL;
    wire sel_dir = paddr == OFS_DIR;
    wire sel_ramp = paddr == OFS_RAMP;
    wire sel_stat = paddr == OFS_STATUS;
    wire sel_tnow = paddr == OFS_TIMER_NOW;
    wire sel_tab = (paddr[7:6] == TABLE_PAGE) & aligned;
    wire [3:0] tab_idx = paddr[5:2];
    wire mapped = sel_ctrl | sel_dir | sel_ramp | sel_stat | sel_tnow | sel_tab;
    wire mode_int = run_mode_r == RUN_MODE_INTERNAL;
    // a running cycle may not be retargeted from software
    wire cycling = mode_int & seq_mode_r[0] & (st_r != S_IDLE);
    wire ctrl_locked = sel_ctrl & cycling;
    wire bad_wr = pwrite & (sel_stat | sel_tnow | ctrl_locked);
    wire err = acc & (~mapped | bad_wr);
    wire wr_ok = acc & pwrite & ~err;
    wire [15:0] tab_lim = tab_idx[3] ? TIMER_MAX : FREQ_MAX;
    wire [15:0] tab_wdata = clamp16(pwdata, tab_lim);

    assign pready = 1'b1;
    assign pslverr = err;

    assign prdata = !psel ? 32'h0 :
        sel_ctrl ? {26'h0, seq_mode_r, 1'b0, run_mode_r} :
        sel_dir ? {24'h0, dir_r} :
        sel_ramp ? {16'h0, ramp_r} :
        sel_stat ? {27'h0, out_run, step_r, seq_active} :
        sel_tnow ? {16'h0, timer_r} :
        sel_tab ? {16'h0, rdata_a} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_mode_r <= 3'h0;
            seq_mode_r <= SEQ_ONCE;
            dir_r <= 8'h00;
            ramp_r <= 16'h0000;
        end else if (wr_ok) begin
            if (sel_ctrl) begin
                run_mode_r <= pwdata[CTRL_RUN_LSB +: 3];
                seq_mode_r <= pwdata[CTRL_SEQ_LSB +: 2];
            end
            if (sel_dir) begin
                dir_r <= pwdata[7:0];
            end
            if (sel_ramp) begin
                ramp_r <= pwdata[15:0];
            end
        end
    end

    // ------------------------------------------------------------
    // step tables: 0 main speed, 1..7 steps, 8..15 step timers
    // ------------------------------------------------------------
    // plain run reads the main speed entry, whatever step a stopped sequence left behind
    wire [3:0] seq_addr = !mode_int ? 4'h0 :
        (st_r == S_RDT) ? (TIMER_IDX_BASE | {1'b0, step_r}) : {1'b0, step_r};

    sss_table_mem #(
        .AW(4),
        .DW(16)
    ) u_tab (
        .clk(pclk),
        .rst_n(presetn),
        .we(wr_ok & sel_tab),
        .waddr(tab_idx),
        .wdata(tab_wdata),
        .raddr_a(tab_idx),
        .rdata_a(rdata_a),
        .raddr_b(seq_addr),
        .rdata_b(rdata_b)
    );

    // ------------------------------------------------------------
    // 0.1 s tick, restarted whenever a timed state is entered
    // ------------------------------------------------------------
    wire timed = (st_r == S_RUN) | (st_r == S_GAP);
    wire tick = timed & (div_r == 24'(TICK_CYCLES - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 24'h0;
        end else if (!timed || tick) begin
            div_r <= 24'h0;
        end else begin
            div_r <= div_r + 24'h1;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    wire last = step_r == LAST_STEP;
    // a pass with no used step would spin forever, so it ends the run
    wire end_run = last & (~seq_mode_r[0] | ~used_r);
    wire expire = (st_r == S_RUN) & tick & (timer_r == 16'h1);

    always_comb begin
        st_nxt = st_r;
        step_nxt = step_r;
        timer_nxt = timer_r;
        gap_nxt = gap_r;
        freq_nxt = freq_r;
        used_nxt = used_r;
        if (!mode_int || stop_any) begin
            st_nxt = S_IDLE;
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (run_pulse) begin
                        st_nxt = S_RDF;
                        step_nxt = 3'h0;
                        used_nxt = 1'b0;
                    end
                end
                S_RDF: begin
                    st_nxt = S_RDT;
                end
                S_RDT: begin
                    freq_nxt = rdata_b;
                    st_nxt = S_CHK;
                end
                S_CHK: begin
                    if (rdata_b == 16'h0) begin
                        step_nxt = step_r + 3'h1;
                        st_nxt = end_run ? S_IDLE : S_RDF;
                        used_nxt = last ? 1'b0 : used_r;
                    end else begin
                        timer_nxt = rdata_b;
                        used_nxt = 1'b1;
                        st_nxt = S_RUN;
                    end
                end
                S_RUN: begin
                    if (expire) begin
                        step_nxt = step_r + 3'h1;
                        used_nxt = last ? 1'b0 : used_r;
                        gap_nxt = 16'(GAP_TICKS);
                        if (end_run) begin
                            st_nxt = S_IDLE;
                        end else if (seq_mode_r[1]) begin
                            st_nxt = S_GAP;
                        end else begin
                            st_nxt = S_RDF;
                        end
                    end else if (tick) begin
                        timer_nxt = timer_r - 16'h1;
                    end
                end
                S_GAP: begin
                    if (tick) begin
                        if (gap_r <= 16'h1) begin
                            st_nxt = S_RDF;
                        end else begin
                            gap_nxt = gap_r - 16'h1;
                        end
                    end
                end
                default: begin
                    st_nxt = S_IDLE;
                end
            endcase
        end
    end

    // outside the internal mode the main speed runs on plain run/stop
    assign norm_run_nxt = mode_int ? 1'b0 : stop_any ? 1'b0 : run_pulse ? 1'b1 : norm_run_r;
    wire run_nxt = mode_int ? (st_nxt == S_RUN) : norm_run_nxt;
    assign out_freq_nxt = !run_nxt ? 16'h0 : mode_int ? freq_nxt : rdata_b;
    // external direction only counts outside the internal mode
    wire rev_nxt = mode_int ? dir_r[step_nxt] : fwd_rev_s;
    wire [1:0] ramp_nxt = mode_int ? ramp_of(ramp_r, step_nxt) : 2'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= S_IDLE;
            step_r <= 3'h0;
            timer_r <= 16'h0;
            gap_r <= 16'h0;
            freq_r <= 16'h0;
            used_r <= 1'b0;
            norm_run_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            step_r <= step_nxt;
            timer_r <= timer_nxt;
            gap_r <= gap_nxt;
            freq_r <= freq_nxt;
            used_r <= used_nxt;
            norm_run_r <= norm_run_nxt;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_run <= 1'b0;
            out_freq <= 16'h0;
            out_reverse <= 1'b0;
            out_ramp_sel <= 2'h0;
        end else begin
            out_run <= run_nxt;
            out_freq <= out_freq_nxt;
            out_reverse <= rev_nxt;
            out_ramp_sel <= ramp_nxt;
        end
    end

    assign seq_active = st_r != S_IDLE;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    seq_mode_gate_a: assert property (
        !mode_int |=> st_r == S_IDLE)
        else $error("sequencer active outside internal run mode");

    run_ignored_a: assert property (
        (cycling && st_r == S_RUN && run_pulse && !stop_any && !tick) |=>
        (st_r == S_RUN && $stable(step_r)))
        else $error("run command disturbed a cycling sequence");

    stop_obeyed_a: assert property (
        stop_any [*2] |-> (!out_run && out_freq == 16'h0))
        else $error("output still running under stop");

    once_ends_a: assert property (
        (expire && last && !seq_mode_r[0] && mode_int && !stop_any) |=>
        (st_r == S_IDLE) ##1 !out_run)
        else $error("single cycle did not stop after last step");

    cycle_wrap_a: assert property (
        (expire && last && seq_mode_r == SEQ_CYCLE && mode_int && !stop_any) |=>
        (step_r == 3'h0 && st_r == S_RDF) ##3 (st_r inside {S_RUN, S_RDF}))
        else $error("cycling did not restart at the main speed");

    step_gap_a: assert property (
        (expire && !end_run && seq_mode_r[1] && mode_int && !stop_any) |=>
        (!out_run && st_r == S_GAP))
        else $error("no stop at step change in intervention mode");

    freq_range_a: assert property (
        out_freq <= FREQ_MAX)
        else $error("output frequency above limit");

    timer_load_a: assert property (
        (st_r == S_CHK && rdata_b != 16'h0 && mode_int && !stop_any) |=>
        (timer_r == $past(rdata_b) && out_run))
        else $error("step timer not loaded from table");

    dir_out_a: assert property (
        (mode_int && out_run) |-> out_reverse == dir_r[step_r])
        else $error("direction differs from mask");

    ramp_out_a: assert property (
        (mode_int && out_run) |-> out_ramp_sel == ramp_of(ramp_r, step_r))
        else $error("ramp selection differs from word");

    zero_skip_a: assert property (
        (st_r == S_CHK && rdata_b == 16'h0) |=> st_r != S_RUN)
        else $error("zero timer step was run");

    step_order_a: assert property (
        (expire && !last && mode_int && !stop_any) |=> step_r == $past(step_r) + 3'h1)
        else $error("steps out of order");

endmodule : sss_sequencer

// ==== sss_stage_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// motor output stage: counts every run segment it is handed, logs the first sixteen
// ------------------------------------------------------------
module sss_stage_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clr,
    input wire logic [15:0] out_freq,
    input wire logic out_reverse,
    input wire logic [1:0] out_ramp_sel,
    input wire logic out_run,
    output logic [18:0] seg_info [0:15],
    output logic [15:0] seg_len [0:15],
    output logic [15:0] seg_gap [0:15],
    output logic [7:0] n_seg
);
    logic run_q;
    logic [15:0] cnt;
    // cnt counts samples since the last change of out_run, so it is a length or a pause
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            n_seg <= 8'h00;
            run_q <= 1'b0;
            cnt <= 16'h0000;
        end else if (clr) begin
            n_seg <= 8'h00;
            cnt <= 16'h0000;
            run_q <= out_run;
        end else begin
            run_q <= out_run;
            cnt <= (out_run != run_q) ? 16'h0001 : cnt + 16'h0001;
            if (out_run && !run_q) begin
                n_seg <= n_seg + 8'h01;
            end
            // only the first sixteen segments are kept, later ones are counted
            if (out_run && !run_q && n_seg < 8'h10) begin
                seg_info[n_seg[3:0]] <= {out_reverse, out_ramp_sel, out_freq};
                seg_gap[n_seg[3:0]] <= cnt;
            end
            if (!out_run && run_q && n_seg <= 8'h10 && n_seg != 8'h00) begin
                seg_len[n_seg[3:0] - 4'h1] <= cnt;
            end
        end
    end
endmodule : sss_stage_model

// ==== sss_table_mem.sv ====
`timescale 1ns/100ps
module sss_table_mem #(
    parameter int AW = 4,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr_a,
    output logic [DW-1:0] rdata_a,
    input wire logic [AW-1:0] raddr_b,
    output logic [DW-1:0] rdata_b
);

    logic [DW-1:0] mem_r [2**AW];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_r[i] <= '0;
            end
            rdata_a <= '0;
            rdata_b <= '0;
        end else begin
            if (we) begin
                mem_r[waddr] <= wdata;
            end
            rdata_a <= mem_r[raddr_a];
            rdata_b <= mem_r[raddr_b];
        end
    end

endmodule : sss_table_mem

// ==== test_auto_speed_step_sequencer.sv ====
`timescale 1ns/100ps
module test_auto_speed_step_sequencer;
    import sss_pkg::*;
    localparam int TK = 4;
    localparam int GP = 1;
    localparam logic [7:0] DIRM = 8'h4A;
    localparam logic [15:0] RAMPW = 16'hE4B1;
    typedef struct packed {
        logic w;
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic e;
    } sss_row_t;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, clr;
    logic run_cmd, stop_cmd, ext_fault, estop, ext_fwd_rev, out_reverse, out_run, seq_active;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] out_freq;
    logic [1:0] out_ramp_sel;
    logic [18:0] seg_info [0:15];
    logic [15:0] seg_len [0:15];
    logic [15:0] seg_gap [0:15];
    logic [7:0] n_seg;
    logic [15:0] fr [0:7];
    logic [15:0] tm [0:7];
    sss_row_t rows [0:11];
    int n_mismatch = 0;
    int num_checks = 0;

    sss_sequencer #(.TICK_CYCLES(TK), .GAP_TICKS(GP)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .run_cmd(run_cmd), .stop_cmd(stop_cmd), .ext_fault(ext_fault), .estop(estop),
        .ext_fwd_rev(ext_fwd_rev), .out_freq(out_freq), .out_reverse(out_reverse),
        .out_ramp_sel(out_ramp_sel), .out_run(out_run), .seq_active(seq_active)
    );
    sss_stage_model u_stage (
        .pclk(pclk), .presetn(presetn), .clr(clr), .out_freq(out_freq),
        .out_reverse(out_reverse), .out_ramp_sel(out_ramp_sel), .out_run(out_run),
        .seg_info(seg_info), .seg_len(seg_len), .seg_gap(seg_gap), .n_seg(n_seg)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        num_checks++;
        if (got !== ex) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 100);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 100) chk("pready", 1, 0);
    endtask : apb

    task cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    // clears the log, then a run pulse long enough for the pin synchroniser
    task start(input logic [31:0] ctrl);
        apb(1'b1, OFS_CTRL, ctrl);
        @(posedge pclk);
        clr <= 1'b1;
        run_cmd <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        cyc(3);
        run_cmd <= 1'b0;
    endtask : start

    task wait_seg(input int n);
        int k;
        k = 0;
        while (n_seg < n && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        chk("segments reached", 1, n_seg >= n);
    endtask : wait_seg

    task wait_idle;
        int k;
        k = 0;
        cyc(10);
        while (seq_active !== 1'b0 && k < 2000) begin
            @(posedge pclk);
            k++;
        end
        chk("sequence ended", 0, seq_active);
    endtask : wait_idle

    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        int j;
        {psel, penable, pwrite, run_cmd, stop_cmd, ext_fault, estop, ext_fwd_rev, clr} = '0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        presetn = 1'b0;
        rows = '{
            '{1'b0, OFS_DIR, 32'h0, 32'h0, 1'b0}, '{1'b1, OFS_DIR, 32'h4A, 32'h0, 1'b0},
            '{1'b0, OFS_DIR, 32'h0, 32'h4A, 1'b0}, '{1'b1, OFS_RAMP, 32'hE4B1, 32'h0, 1'b0},
            '{1'b0, OFS_RAMP, 32'h0, 32'hE4B1, 1'b0}, '{1'b1, 8'h40, 32'hFFFF, 32'h0, 1'b0},
            '{1'b0, 8'h40, 32'h0, 32'h9C40, 1'b0}, '{1'b1, 8'h7C, 32'hFFFF, 32'h0, 1'b0},
            '{1'b0, 8'h7C, 32'h0, 32'hFDE8, 1'b0}, '{1'b1, OFS_STATUS, 32'h1, 32'h0, 1'b1},
            '{1'b0, 8'h20, 32'h0, 32'h0, 1'b1}, '{1'b1, OFS_TIMER_NOW, 32'h1, 32'h0, 1'b1}};
        cyc(5);
        chk("out_run in reset", 0, out_run);
        presetn <= 1'b1;
        for (int i = 0; i < 12; i++) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("pslverr", rows[i].e, er);
            if (!rows[i].w) chk("prdata", rows[i].x, rd);
        end
        for (int i = 0; i < 8; i++) begin
            fr[i] = 16'h1000 + 16'(i);
            tm[i] = (i == 1) ? 16'h0000 : ((i == 7) ? 16'h0002 : 16'h0001);
            apb(1'b1, 8'h40 + 8'(4 * i), {16'h0000, fr[i]});
            apb(1'b1, 8'h60 + 8'(4 * i), {16'h0000, tm[i]});
        end
        // single pass, direction pin pulling the other way throughout
        ext_fwd_rev <= 1'b1;
        start(32'h04);
        wait_idle();
        cyc(20);
        chk("pass segments", 7, n_seg);
        chk("out_run after pass", 0, out_run);
        j = 0;
        for (int i = 0; i < 8; i++) begin
            if (tm[i] != 16'h0000) begin
                chk("segment info", {DIRM[i], RAMPW[2*i+:2], fr[i]}, seg_info[j]);
                chk("segment length", tm[i] * TK, seg_len[j]);
                j++;
            end
        end
        start(32'h04);
        wait_seg(1);
        wait_idle();
        // single pass with a stop before every step change
        start(32'h24);
        wait_idle();
        chk("paused pass segments", 7, n_seg);
        chk("pause length", 1, seg_gap[2] >= 3 + GP * TK);
        // cycling runs ended by each kind of stop in turn
        for (int k = 0; k < 3; k++) begin
            start(k == 1 ? 32'h34 : 32'h14);
            wait_seg(k == 0 ? 9 : 2);
            if (k == 0) begin
                chk("wrap step", {DIRM[0], RAMPW[1:0], fr[0]}, seg_info[7]);
                apb(1'b1, OFS_CTRL, 32'h04);
                chk("ctrl refused", 1, er);
                apb(1'b0, OFS_CTRL, 32'h0);
                chk("ctrl kept", 32'h14, rd);
                apb(1'b0, OFS_STATUS, 32'h0);
                chk("status active", 1, rd[0]);
                run_cmd <= 1'b1;
                cyc(4);
                run_cmd <= 1'b0;
                cyc(4);
                chk("run ignored", 1, seq_active);
            end
            if (k == 1) chk("cycling pause", 1, seg_gap[1] >= 3 + GP * TK);
            {estop, ext_fault, stop_cmd} <= 3'b001 << k;
            cyc(6);
            chk("stopped", 0, out_run);
            chk("idle after stop", 0, seq_active);
            {estop, ext_fault, stop_cmd} <= 3'b000;
            cyc(3);
        end
        // plain run mode: sequence mode has no effect, direction pin obeyed
        start(32'h10);
        cyc(40);
        chk("plain run", 1, out_run);
        chk("plain freq", fr[0], out_freq);
        chk("plain reverse", 1, out_reverse);
        chk("plain ramp", 0, out_ramp_sel);
        chk("plain no sequence", 0, seq_active);
        chk("plain no stepping", 1, n_seg);
        stop_cmd <= 1'b1;
        cyc(6);
        chk("plain stopped", 0, out_run);
        stop_cmd <= 1'b0;
        // reset in mid-run
        start(32'h04);
        wait_seg(1);
        presetn <= 1'b0;
        cyc(2);
        chk("run in reset", 0, out_run);
        chk("active in reset", 0, seq_active);
        presetn <= 1'b1;
        apb(1'b0, OFS_DIR, 32'h0);
        chk("mask after reset", 0, rd);
        print_verdict();
    end
endmodule : test_auto_speed_step_sequencer
